// ==== pkg/smct_consts.vh ====
`ifndef SMCT_CONSTS_VH
`define SMCT_CONSTS_VH
`define SMCT_DATA_W 8
`define SMCT_PS_W 8
`define SMCT_DLY_W 8
`define SMCT_FIFO_DEPTH 4
`define SMCT_CNT_W 10
`define SMCT_CNT_ZERO 10'h000
`define SMCT_CNT_ONE 10'h001
`define SMCT_HOLD_EXTRA 10'h001
`define SMCT_ZERO_PS_PERIOD 10'h002
`define SMCT_MIN_PERIOD_NS 50
`define SMCT_CLK_PERIOD_NS 5
`define SMCT_MIN_DIV ((`SMCT_MIN_PERIOD_NS + `SMCT_CLK_PERIOD_NS - 1) / `SMCT_CLK_PERIOD_NS)
`endif

// ==== core/smct_sync.v ====
`timescale 1ns/1ps
`default_nettype none
module smct_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire rst_n,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta;
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= {W{1'b0}};
			q <= {W{1'b0}};
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// ==== core/smct_fifo.v ====
`timescale 1ns/1ps
`default_nettype none
module smct_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk,
	input wire rst_n,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	reg full;
	reg empty;
	wire push;
	wire pop;
	reg [AW:0] next_count;
	integer i;
	assign push = in_valid && !full;
	assign pop = out_ready && !empty;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr];
	always @*
	begin
		next_count = count;
		if (push && !pop)
			next_count = count + 1'b1;
		else if (pop && !push)
			next_count = count - 1'b1;
	end
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			full <= 1'b0;
			empty <= 1'b1;
			for (i = 0; i < DEPTH; i = i + 1)
				mem[i] <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			count <= next_count;
			full <= (next_count == DEPTH);
			empty <= (next_count == {(AW+1){1'b0}});
		end
	end
endmodule
`default_nettype wire

// ==== core/smct_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "smct_consts.vh"
module smct_top #(
	parameter DATA_W = `SMCT_DATA_W,
	parameter FIFO_DEPTH = `SMCT_FIFO_DEPTH
) (
	input wire clk,
	input wire nrst,
	input wire master_select,
	input wire clock_phase,
	input wire clock_polarity,
	input wire [`SMCT_PS_W-1:0] prescale_value,
	input wire [`SMCT_DLY_W-1:0] cs_to_clock_delay,
	input wire [`SMCT_DLY_W-1:0] clock_to_cs_delay,
	input wire [`SMCT_DLY_W-1:0] cs_hold_count,
	input wire [DATA_W-1:0] tx_data,
	input wire tx_valid,
	output wire tx_ready,
	output reg [DATA_W-1:0] rx_data,
	output reg rx_valid,
	output reg busy,
	output reg rate_error,
	output reg serial_clock_out,
	output reg serial_clock_oe,
	output reg master_data_out,
	output reg master_data_oe,
	output reg chip_select_n,
	input wire master_data_in,
	input wire slave_enable_in
);
	localparam S_IDLE = 3'h0;
	localparam S_SETUP = 3'h1;
	localparam S_WAIT_EN = 3'h2;
	localparam S_HOLD = 3'h3;
	localparam S_TRAIL = 3'h4;
	localparam S_GAP = 3'h5;
	localparam S_TAIL = 3'h6;
	localparam BIT_W = 4;

	reg rst_meta;
	reg rst_n;
	reg [2:0] state;
	reg [`SMCT_CNT_W-1:0] cnt;
	reg [BIT_W-1:0] bit_cnt;
	reg [DATA_W-1:0] shift;
	reg pol;
	reg pha;
	reg [`SMCT_CNT_W-1:0] period;
	wire [`SMCT_CNT_W-1:0] half_a;
	wire [`SMCT_CNT_W-1:0] half_b;
	wire [DATA_W-1:0] fifo_data;
	wire fifo_valid;
	wire fifo_pop;
	wire [1:0] pins_sync;
	wire data_in_s;
	wire enable_n_s;
	wire last_bit;

	// Reset release through two flops
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	smct_sync #(
		.W(2)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({master_data_in, slave_enable_in}),
		.q(pins_sync)
	);
	assign data_in_s = pins_sync[1];
	assign enable_n_s = pins_sync[0];

	assign fifo_pop = (state == S_IDLE) && master_select && fifo_valid;

	smct_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	always @*
	begin
		if (prescale_value == {`SMCT_PS_W{1'b0}})
			period = `SMCT_ZERO_PS_PERIOD;
		else
			period = {{(`SMCT_CNT_W-`SMCT_PS_W){1'b0}}, prescale_value} + `SMCT_CNT_ONE;
	end
	assign half_a = period >> 1;
	assign half_b = period - half_a;
	assign last_bit = (bit_cnt == DATA_W - 1);

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= S_IDLE;
			cnt <= `SMCT_CNT_ZERO;
			bit_cnt <= {BIT_W{1'b0}};
			shift <= {DATA_W{1'b0}};
			pol <= 1'b0;
			pha <= 1'b0;
			rx_data <= {DATA_W{1'b0}};
			rx_valid <= 1'b0;
			busy <= 1'b0;
			rate_error <= 1'b0;
			serial_clock_out <= 1'b0;
			serial_clock_oe <= 1'b0;
			master_data_out <= 1'b0;
			master_data_oe <= 1'b0;
			chip_select_n <= 1'b1;
		end
		else
		begin
			rx_valid <= 1'b0;
			serial_clock_oe <= master_select;
			master_data_oe <= master_select;
			// flag a period below the slave minimum
			rate_error <= (period < `SMCT_MIN_DIV);
			case (state)
			S_IDLE:
			begin
				serial_clock_out <= clock_polarity;
				chip_select_n <= 1'b1;
				busy <= 1'b0;
				if (fifo_pop)
				begin
					shift <= fifo_data;
					pol <= clock_polarity;
					pha <= clock_phase;
					bit_cnt <= {BIT_W{1'b0}};
					chip_select_n <= 1'b0;
					busy <= 1'b1;
					cnt <= {{(`SMCT_CNT_W-`SMCT_DLY_W){1'b0}}, cs_to_clock_delay};
					state <= S_SETUP;
				end
			end
			S_SETUP:
			begin
				if (cnt == `SMCT_CNT_ZERO)
				begin
					// sample slave enable at cs-to-clock delay
					// sample within delay plus 2 of write
					if (!enable_n_s)
					begin
						// sample edge already spent one of the 2
						cnt <= {{(`SMCT_CNT_W-`SMCT_DLY_W){1'b0}}, cs_hold_count};
						state <= S_HOLD;
					end
					else
						state <= S_WAIT_EN;
				end
				else
					cnt <= cnt - `SMCT_CNT_ONE;
			end
			S_WAIT_EN:
			begin
				// hold off clocking until enable low
				if (!enable_n_s)
				begin
					cnt <= {{(`SMCT_CNT_W-`SMCT_DLY_W){1'b0}}, cs_hold_count} + `SMCT_HOLD_EXTRA;
					state <= S_HOLD;
				end
			end
			S_HOLD, S_GAP:
			begin
				if (cnt == `SMCT_CNT_ZERO)
				begin
					// leading edge: first after delay, hold and 2, later ones after half_a gap
					serial_clock_out <= ~pol;
					// data shown half a period before trailing edge
					master_data_out <= shift[DATA_W-1];
					// phase one captures on the leading edge
					if (pha)
						shift <= {shift[DATA_W-2:0], data_in_s};
					else
						shift <= {shift[DATA_W-2:0], 1'b0};
					cnt <= half_b - `SMCT_CNT_ONE;
					state <= S_TRAIL;
				end
				else
					cnt <= cnt - `SMCT_CNT_ONE;
			end
			S_TRAIL:
			begin
				if (cnt == `SMCT_CNT_ZERO)
				begin
					serial_clock_out <= pol;
					// phase zero captures on the trailing edge
					if (!pha)
						shift[0] <= data_in_s;
					bit_cnt <= bit_cnt + 1'b1;
					if (last_bit)
					begin
						// tail of half, delay and one cycle
						cnt <= half_a + {{(`SMCT_CNT_W-`SMCT_DLY_W){1'b0}}, clock_to_cs_delay};
						state <= S_TAIL;
					end
					else
					begin
						cnt <= half_a - `SMCT_CNT_ONE;
						state <= S_GAP;
					end
				end
				else
					cnt <= cnt - `SMCT_CNT_ONE;
			end
			S_TAIL:
			begin
				if (cnt == `SMCT_CNT_ZERO)
				begin
					chip_select_n <= 1'b1;
					rx_data <= shift;
					rx_valid <= 1'b1;
					state <= S_IDLE;
				end
				else
					cnt <= cnt - `SMCT_CNT_ONE;
			end
			default:
			begin
				state <= S_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== sim/smct_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module smct_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic master_select,
	input wire logic clock_polarity,
	input wire logic [7:0] prescale_value,
	input wire logic [7:0] cs_to_clock_delay,
	input wire logic [7:0] clock_to_cs_delay,
	input wire logic [7:0] cs_hold_count,
	input wire logic busy,
	input wire logic rate_error,
	input wire logic rx_valid,
	input wire logic serial_clock_out,
	input wire logic serial_clock_oe,
	input wire logic chip_select_n,
	input wire logic slave_enable_in
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	logic p = 1'b0;
	logic [9:0] n = 10'h000;
	logic [9:0] m = 10'h000;
	logic [9:0] k = 10'h000;
	logic [9:0] e = 10'h000;
	wire t = p != serial_clock_out;
	wire [9:0] per = prescale_value == 8'h00 ? 10'h002 : {2'h0, prescale_value} + 10'h001;
	wire [9:0] lead = {2'h0, cs_to_clock_delay} + {2'h0, cs_hold_count} + 10'h002;
	// Edge, frame and enable counters
	always @(posedge clk)
	begin
		p <= serial_clock_out;
		n <= chip_select_n ? 10'h000 : n + 10'h001;
		m <= t ? 10'h001 : m + 10'h001;
		k <= slave_enable_in ? 10'h000 : (k == 10'h3FF ? k : k + 10'h001);
		e <= chip_select_n ? 10'h000 : e + {9'h000, t};
	end
	sequence s_end;
		!chip_select_n ##1 chip_select_n;
	endsequence
	AST_MASTER: assert property ($fell(chip_select_n) |-> $past(master_select) && serial_clock_oe)
		else $error("frame outside master mode");
	AST_IDLE: assert property (s_end |-> serial_clock_out == clock_polarity && rx_valid)
		else $error("bad idle level");
	AST_LEAD: assert property (!chip_select_n && t && e == 10'h000 && k > n |-> n == lead)
		else $error("bad lead time");
	AST_HOLDOFF: assert property (!chip_select_n && t && e == 10'h000 |-> k >= {2'h0, cs_hold_count} + 10'h002)
		else $error("clock before enable");
	AST_HALF: assert property (e != 10'h000 && t |-> m == (serial_clock_out == clock_polarity ? per - per / 2 : per / 2))
		else $error("bad half period");
	AST_TAIL: assert property (s_end |-> m == per / 2 + {2'h0, clock_to_cs_delay} + 10'h001)
		else $error("bad tail time");
	AST_RATE: assert property (busy && $stable(prescale_value) |-> rate_error == (per < 10'h00A))
		else $error("bad rate flag");
	AST_COUNT: assert property (s_end |-> e == 10'h010)
		else $error("bad edge count");
endmodule
bind smct_top smct_checker chk (.clk(clk), .nrst(nrst), .master_select(master_select),
	.clock_polarity(clock_polarity), .prescale_value(prescale_value), .cs_to_clock_delay(cs_to_clock_delay),
	.clock_to_cs_delay(clock_to_cs_delay), .cs_hold_count(cs_hold_count), .busy(busy), .rate_error(rate_error),
	.rx_valid(rx_valid), .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
	.chip_select_n(chip_select_n), .slave_enable_in(slave_enable_in));
`default_nettype wire

// ==== sim/smct_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module smct_slave (
	input wire logic clk,
	input wire logic serial_clock_out,
	input wire logic chip_select_n,
	input wire logic master_data_out,
	input wire logic clock_polarity,
	input wire logic [7:0] lag,
	output logic master_data_in,
	output logic slave_enable_in,
	output logic [7:0] got
);
	logic q = 1'b0;
	logic [7:0] sh = 8'h00;
	logic [7:0] w = 8'h00;
	initial
	begin
		master_data_in = 1'b0;
		slave_enable_in = 1'b1;
		got = 8'h5A;
	end
	always @(posedge clk)
	begin
		q <= serial_clock_out;
		if (chip_select_n)
		begin
			slave_enable_in <= lag != 8'h00;
			w <= 8'h00;
			sh <= ~got;
			master_data_in <= ~master_data_in;
		end
		else
		begin
			w <= w + 8'h01;
			if (w >= lag)
				slave_enable_in <= 1'b0;
			if (q != serial_clock_out)
				if (serial_clock_out == clock_polarity)
					got <= {got[6:0], master_data_out};
				else
				begin
					master_data_in <= sh[7];
					sh <= {sh[6:0], 1'b0};
				end
		end
	end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ms = 1'b0;
	logic pol = 1'b0;
	logic tv = 1'b0;
	logic fast = 1'b0;
	logic [7:0] ps = 8'h09;
	logic [7:0] c2t = 8'h03;
	logic [7:0] t2c = 8'h00;
	logic [7:0] hold = 8'h00;
	logic [7:0] td = 8'h00;
	logic [7:0] lag = 8'h00;
	logic [7:0] prev = 8'h5A;
	logic [7:0] txq[$];
	wire tr, rv, bz, re, sc, sco, mdo, mdoe, csn, mdi, en;
	wire [7:0] rd, got;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int i, j;
	always #2.5 clk = ~clk;
	smct_top dut (.clk(clk), .nrst(nrst), .master_select(ms), .clock_phase(1'b0), .clock_polarity(pol),
		.prescale_value(ps), .cs_to_clock_delay(c2t), .clock_to_cs_delay(t2c), .cs_hold_count(hold),
		.tx_data(td), .tx_valid(tv), .tx_ready(tr), .rx_data(rd), .rx_valid(rv), .busy(bz), .rate_error(re),
		.serial_clock_out(sc), .serial_clock_oe(sco), .master_data_out(mdo), .master_data_oe(mdoe),
		.chip_select_n(csn), .master_data_in(mdi), .slave_enable_in(en));
	smct_slave peer (.clk(clk), .serial_clock_out(sc), .chip_select_n(csn), .master_data_out(mdo),
		.clock_polarity(pol), .lag(lag), .master_data_in(mdi), .slave_enable_in(en), .got(got));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task push(input logic [7:0] d);
		td <= d;
		tv <= 1'b1;
		@(posedge clk);
		while (tr !== 1'b1)
			@(posedge clk);
		txq.push_back(d);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 30000)
		begin
			bad_count++;
			summarize();
		end
	end
	always @(posedge clk)
		if (rv === 1'b1)
		begin
			check(got, txq.pop_front());
			if (!fast)
				check(rd, ~prev);
			prev = got;
		end
	initial
	begin
		void'($urandom(32'h8FC6E088));
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		for (i = 0; i < 10; i++)
		begin
			ps <= i == 2 ? 8'h00 : 8'h09 + 8'($urandom % 12);
			fast = i == 2;
			pol <= 1'($urandom);
			c2t <= 8'($urandom % 9);
			t2c <= 8'($urandom % 6);
			hold <= 8'($urandom % 6);
			lag <= i % 3 == 0 ? 8'($urandom % 14) : 8'h00;
			ms <= 1'b0;
			for (j = 0; j < 4; j++)
				push(8'($urandom));
			repeat (20) @(posedge clk);
			check({4'h0, tr, csn, sco, mdoe}, 8'h04);
			ms <= 1'b1;
			push(8'($urandom));
			push(8'($urandom));
			tv <= 1'b0;
			while (txq.size() != 0 || csn !== 1'b1)
				@(posedge clk);
			@(posedge clk);
			$display("test %0d done", i);
		end
		summarize();
	end
endmodule
`default_nettype wire
